// ---- design/sol_defs.svh ----
// Constants for the strap option loader: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the loader's design files.
`ifndef SOL_DEFS_SVH
`define SOL_DEFS_SVH

// Register offsets on the plain register port (byte addresses)
`define SOL_OFF_BMCR     8'h00
`define SOL_OFF_ANAR     8'h04
`define SOL_OFF_ADDR     8'h08
`define SOL_OFF_STRAP    8'h0C

// Basic mode control fields
`define SOL_BMCR_RST     15
`define SOL_BMCR_SPD     13
`define SOL_BMCR_ANE     12
`define SOL_BMCR_DPX     8
// Advertisement field, four capability bits
`define SOL_ANAR_LSB     5
`define SOL_ANAR_MSB     8
// Address control fields
`define SOL_ADDR_ISO     5
`define SOL_ADDR_FIB     6

// Internal pull directions: fiber_n, autoneg_enable_strap, mode_hi, mode_lo, addr[4:0]
`define SOL_STRAP_PULL   9'h1E1
// Reset value of the captured strap word before any capture
`define SOL_STRAP_RST    9'h000

// Settling time of pins after reset release, and the clock period
`define SOL_SETTLE_NS    100
`define SOL_CLK_NS       20
// Least time rounds up to whole cycles
`define SOL_SETTLE_CYC   ((`SOL_SETTLE_NS + `SOL_CLK_NS - 1) / `SOL_CLK_NS)

`endif

// ---- design/sol_pkg.sv ----
// Types shared by the strap option loader files.
// Assumes sol_defs.svh holds all numeric constants.
package sol_pkg;

   // Raw strap word, one bit per strap pin
   typedef struct packed {
      logic       fiber_n;   // Zero selects fiber
      logic       autoneg_enable_strap;     // Auto-negotiation enable strap
      logic       mode_hi;   // High mode strap
      logic       mode_lo;   // Low mode strap
      logic [4:0] addr;      // Management address strap
   } sol_straps_t;

   // Decoded initial configuration
   typedef struct packed {
      logic       isolate;   // Strapped address was zero
      logic       fiber;     // Fiber mode
      logic       autoneg_enable_strap;     // Negotiate
      logic       speed100;  // 100 Mb/s
      logic       duplex;    // Full duplex
      logic [3:0] advert;    // 100FD, 100HD, 10FD, 10HD
   } sol_cfg_t;

   // Loader sequence
   typedef enum logic [1:0] {
      SOL_WAIT,
      SOL_LOAD,
      SOL_RUN
   } sol_state_t;

endpackage

// ---- design/sol_sync.sv ----
// Two-flop synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow static level, such as a strap pin.
`timescale 1ns/1ps
module sol_sync #(
   parameter int W = 9     // Number of bits
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   // Levels
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_reg;   // First stage, read only by second stage

   // Two stages; bits are independent so no word coherence is needed
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_reg <= '0;
         q_o      <= '0;
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end

endmodule

// ---- design/sol_decode.sv ----
// Decodes a captured strap word into the initial configuration.
// Assumes the strap word is stable; purely combinational.
`timescale 1ns/1ps
module sol_decode
   import sol_pkg::*;
(
   // Captured straps
   input  wire sol_straps_t straps_i,
   // Decoded configuration
   output sol_cfg_t         cfg_o
);

   // Named decode terms
   wire       fiber_w  = ~straps_i.fiber_n;
   wire       an_w     = straps_i.autoneg_enable_strap & ~fiber_w;
   wire [1:0] mode_w   = {straps_i.mode_hi, straps_i.mode_lo};
   wire [3:0] onehot_w = 4'h1 << mode_w;

   // Fiber ignores autoneg_enable_strap and mode_hi: 100 Mb/s, duplex from mode_lo
   // Copper: hi picks speed, lo picks duplex, forced or advertised
   assign cfg_o.isolate  = (straps_i.addr == 5'h00);
   assign cfg_o.fiber    = fiber_w;
   assign cfg_o.autoneg_enable_strap    = an_w;
   assign cfg_o.speed100 = fiber_w | straps_i.mode_hi;
   assign cfg_o.duplex   = straps_i.mode_lo;
   // Advertise only the selected capability when negotiating
   assign cfg_o.advert   = an_w ? onehot_w : 4'h0;

endmodule

// ---- design/sol_loader.sv ----
// Strap option loader: captures strap pins after hardware reset,
// loads the initial configuration, reloads it on software reset.
// Assumes strap pins are held by board resistors or internal pulls
// and that strap_ext_i tells which pins carry an external resistor.
`timescale 1ns/1ps
`include "sol_defs.svh"

////////////////////////////////////////////////////////////////////
// Behaviour
// - Sample all straps at power-up and hardware reset
// - Software reset reloads captured values, no resample
// - Latch five address straps into address register
// - Strapped address zero selects MII isolate
// - Writing address zero never selects isolate
// - Unresisted address defaults to one
// - autoneg_enable_strap picks negotiate or forced with mode straps
// - Copy negotiation straps into control and advertisement
// - Unresisted negotiation straps read all ones
// - Fiber: low mode strap picks duplex, 100 only
// - Fiber ignores autoneg_enable_strap, mode_hi; never negotiates
// - Copper forced: hi speed, lo duplex
// - Fiber with low strap zero is half duplex
module sol_loader
   import sol_pkg::*;
#(
   parameter int SETTLE_CYC = `SOL_SETTLE_CYC  // Pin settling cycles
) (
   // Clock and hardware reset
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   // Strap pins and board resistor presence
   input  wire logic [8:0]   strap_pin_i,
   input  wire logic [8:0]   strap_ext_i,
   // Register port
   input  wire logic [7:0]   reg_addr_i,
   input  wire logic [15:0]  reg_wdata_i,
   input  wire logic         reg_we_i,
   input  wire logic         reg_re_i,
   output logic      [15:0]  reg_rdata_o,
   // Configuration to the transceiver core
   output logic      [4:0]   mgmt_addr_o,
   output logic              isolate_o,
   output logic              fiber_mode_o,
   output logic              an_enable_o,
   output logic              speed100_o,
   output logic              full_duplex_o,
   output logic      [3:0]   advert_o,
   output logic              strap_valid_o
);

   ////////////////////////////////////////////////////////////////
   // Declarations
   logic [17:0] sync_w;            // Synchronised pins and masks
   logic [8:0]  pin_s;             // Synchronised pin levels
   logic [8:0]  ext_s;             // Synchronised resistor mask
   sol_straps_t resolved_w;        // Level each strap actually shows
   sol_straps_t strap_reg;         // Captured straps
   sol_straps_t strap_next;
   sol_cfg_t    cfg_w;             // Decoded configuration
   sol_state_t  state_reg;         // Loader sequence
   sol_state_t  state_next;
   logic [7:0]  cnt_reg;           // Settling counter
   logic [7:0]  cnt_next;
   logic [15:0] rdata_next;        // Read data, one cycle later

   // Settling target cut to the counter width
   localparam logic [7:0] SETTLE = 8'(SETTLE_CYC);

   ////////////////////////////////////////////////////////////////
   // Pin synchroniser: pins are asynchronous to clk_i
   sol_sync #(
      .W (18)
   ) u_sync (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .d_i    ({strap_ext_i, strap_pin_i}),
      .q_o    (sync_w)
   );
   assign pin_s = sync_w[8:0];
   assign ext_s = sync_w[17:9];

   // Without a board resistor the internal pull decides the level
   assign resolved_w = (pin_s & ext_s)
                     | (`SOL_STRAP_PULL & ~ext_s);

   // Decoder
   sol_decode u_decode (
      .straps_i (strap_reg),
      .cfg_o    (cfg_w)
   );

   ////////////////////////////////////////////////////////////////
   // Register port decode
   wire sel_bmcr  = (reg_addr_i == `SOL_OFF_BMCR);
   wire sel_anar  = (reg_addr_i == `SOL_OFF_ANAR);
   wire sel_addr  = (reg_addr_i == `SOL_OFF_ADDR);
   wire sel_strap = (reg_addr_i == `SOL_OFF_STRAP);
   wire running   = (state_reg == SOL_RUN);
   // Writes before the first load are dropped; nothing is set yet
   wire wr_bmcr   = reg_we_i & sel_bmcr & running;
   wire wr_anar   = reg_we_i & sel_anar & running;
   wire wr_addr   = reg_we_i & sel_addr & running;
   // Software reset wins over the field write in the same cycle
   wire sw_rst    = wr_bmcr & reg_wdata_i[`SOL_BMCR_RST];
   wire loading   = (state_reg == SOL_LOAD);
   wire settled   = (cnt_reg >= SETTLE) && (cnt_reg >= 8'h02); // Sync first

   ////////////////////////////////////////////////////////////////
   // Sequence: wait for pins to settle, capture once, load, run
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      strap_next = strap_reg;
      case (state_reg)
         SOL_WAIT: begin
            // Only leaving hardware reset brings us here
            if (settled) begin
               strap_next = resolved_w;
               state_next = SOL_LOAD;
            end else begin
               cnt_next = cnt_reg + 8'h01;
            end
         end
         SOL_LOAD: begin
            state_next = SOL_RUN;
         end
         SOL_RUN: begin
            // Reload from the captured word, pins are not looked at
            if (sw_rst) begin
               state_next = SOL_LOAD;
            end
         end
         default: begin
            state_next = SOL_WAIT;
         end
      endcase
   end

   // Sequence registers; captures change only in SOL_WAIT
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= SOL_WAIT;
         cnt_reg   <= 8'h00;
         strap_reg <= `SOL_STRAP_RST;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         strap_reg <= strap_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Address control register and isolate
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mgmt_addr_o <= 5'h00;
         isolate_o   <= 1'b0;
      end else if (loading) begin
         mgmt_addr_o <= strap_reg.addr;
         isolate_o   <= cfg_w.isolate;
      end else if (wr_addr) begin
         // Isolate is left alone: a written zero does not isolate
         mgmt_addr_o <= reg_wdata_i[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Basic mode control fields
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fiber_mode_o  <= 1'b0;
         an_enable_o   <= 1'b0;
         speed100_o    <= 1'b0;
         full_duplex_o <= 1'b0;
      end else if (loading) begin
         fiber_mode_o  <= cfg_w.fiber;
         an_enable_o   <= cfg_w.autoneg_enable_strap;
         speed100_o    <= cfg_w.speed100;
         full_duplex_o <= cfg_w.duplex;
      end else if (wr_bmcr && !sw_rst) begin
         // Fiber never negotiates and stays at 100 Mb/s
         an_enable_o   <= reg_wdata_i[`SOL_BMCR_ANE] & ~fiber_mode_o;
         speed100_o    <= reg_wdata_i[`SOL_BMCR_SPD] | fiber_mode_o;
         full_duplex_o <= reg_wdata_i[`SOL_BMCR_DPX];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Advertisement register and capture flag
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         advert_o      <= 4'h0;
         strap_valid_o <= 1'b0;
      end else if (loading) begin
         advert_o      <= cfg_w.advert;
         strap_valid_o <= 1'b1;
      end else if (wr_anar) begin
         advert_o <= reg_wdata_i[`SOL_ANAR_MSB:`SOL_ANAR_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read path: data only in the cycle after the strobe, else zero
   always_comb begin
      rdata_next = 16'h0000;
      if (!reg_re_i) begin
         rdata_next = 16'h0000;
      end else if (sel_bmcr) begin
         rdata_next[`SOL_BMCR_SPD] = speed100_o;
         rdata_next[`SOL_BMCR_ANE] = an_enable_o;
         rdata_next[`SOL_BMCR_DPX] = full_duplex_o;
      end else if (sel_anar) begin
         rdata_next[`SOL_ANAR_MSB:`SOL_ANAR_LSB] = advert_o;
      end else if (sel_addr) begin
         rdata_next[4:0]          = mgmt_addr_o;
         rdata_next[`SOL_ADDR_ISO] = isolate_o;
         rdata_next[`SOL_ADDR_FIB] = fiber_mode_o;
      end else if (sel_strap) begin
         rdata_next[8:0] = strap_reg;
      end
   end

   // Read data register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= 16'h0000;
      end else begin
         reg_rdata_o <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   // Software reset write seen while running
   sequence s_swrst;
      running && reg_we_i && sel_bmcr && reg_wdata_i[`SOL_BMCR_RST];
   endsequence
   // Reload passes through SOL_LOAD then returns to SOL_RUN
   sequence s_reload;
      ##1 loading ##1 running;
   endsequence

   property p_capture;
      (state_reg == SOL_WAIT) && settled |=> strap_reg == $past(resolved_w);
   endproperty
   a_capture: assert property (p_capture)
      else $error("straps not captured at end of settling");

   property p_swrst_reload;
      s_swrst |-> s_reload ##0 ((an_enable_o == cfg_w.autoneg_enable_strap)
         && (speed100_o == cfg_w.speed100)
         && (mgmt_addr_o == strap_reg.addr));
   endproperty
   a_swrst_reload: assert property (p_swrst_reload)
      else $error("software reset did not reload captured straps");

   property p_addr_load;
      loading |=> mgmt_addr_o == strap_reg.addr;
   endproperty
   a_addr_load: assert property (p_addr_load)
      else $error("address not loaded from straps");

   property p_isolate;
      loading |=> isolate_o == (strap_reg.addr == 5'h00);
   endproperty
   a_isolate: assert property (p_isolate)
      else $error("isolate does not follow strapped address");

   property p_isolate_write;
      running && !$past(loading) |-> $stable(isolate_o);
   endproperty
   a_isolate_write: assert property (p_isolate_write)
      else $error("isolate changed outside a load");

   property p_default;
      (state_reg == SOL_WAIT) && settled && (ext_s == 9'h000)
         |=> strap_reg == `SOL_STRAP_PULL;
   endproperty
   a_default: assert property (p_default)
      else $error("internal pull defaults not captured");

   property p_fiber;
      running && fiber_mode_o |-> !an_enable_o && speed100_o;
   endproperty
   a_fiber: assert property (p_fiber)
      else $error("fiber mode negotiates or runs below 100");

   property p_forced;
      loading && !strap_reg.autoneg_enable_strap && strap_reg.fiber_n |=>
         !an_enable_o && (speed100_o == $past(strap_reg.mode_hi))
         && (full_duplex_o == $past(strap_reg.mode_lo));
   endproperty
   a_forced: assert property (p_forced)
      else $error("copper forced mode decoded wrongly");

   property p_keep;
      state_reg != SOL_WAIT |=> $stable(strap_reg);
   endproperty
   a_keep: assert property (p_keep)
      else $error("captured straps changed after capture");

   property p_read;
      !reg_re_i |=> reg_rdata_o == 16'h0000;
   endproperty
   a_read: assert property (p_read)
      else $error("read data outside the cycle after a read");

endmodule

// ---- test/sol_strap_board.sv ----
// Board model for the strap pins: fitted resistors or internal pulls.
// Assumes the bench raises alt_i once the straps have been captured.
`timescale 1ns/1ps
`include "sol_defs.svh"
module sol_strap_board (
   // Clock
   input  wire logic       clk_i,
   // Board fit, levels, pins in their normal role
   input  wire logic [8:0] fit_i,
   input  wire logic [8:0] lvl_i,
   input  wire logic       alt_i,
   // Pins seen by the loader
   output logic      [8:0] pin_o,
   output logic      [8:0] ext_o
);
   ////////////////////////////////////////////////////////////////
   // Pattern the pins carry after reset (LED, receive data roles)
   logic [8:0] pat_reg = 9'h0AA;   // Changes every cycle

   // Toggle so a late resample would pick up garbage
   always_ff @(posedge clk_i) begin
      pat_reg <= ~pat_reg;
   end

   // Unfitted pins follow the internal pull direction
   assign pin_o = alt_i ? pat_reg
                        : (fit_i & lvl_i) | (~fit_i & `SOL_STRAP_PULL);
   assign ext_o = fit_i;
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the strap option loader.
// Assumes the board model drives the pins and the bench the registers.
`timescale 1ns/1ps
`include "sol_defs.svh"
module tb;
   import sol_pkg::*;
   ////////////////////////////////////////////////////////////////
   // Signals
   logic        clk_i, nrst_i, reg_we_i, reg_re_i, alt_r, strap_valid_o;
   logic [8:0]  fit_r, lvl_r, pin_w, ext_w;
   logic [7:0]  reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o;
   logic [4:0]  mgmt_addr_o;
   logic        isolate_o, fiber_mode_o, an_enable_o, speed100_o;
   logic        full_duplex_o;
   logic [3:0]  advert_o;
   int          mismatches, checks_done;

   sol_loader #(.SETTLE_CYC(5)) dut_u (.clk_i, .nrst_i,
      .strap_pin_i(pin_w), .strap_ext_i(ext_w), .reg_addr_i,
      .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .mgmt_addr_o,
      .isolate_o, .fiber_mode_o, .an_enable_o, .speed100_o,
      .full_duplex_o, .advert_o, .strap_valid_o);
   sol_strap_board board_u (.clk_i, .fit_i(fit_r), .lvl_i(lvl_r),
      .alt_i(alt_r), .pin_o(pin_w), .ext_o(ext_w));

   // 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [8:0] eff(input logic [8:0] f, l);
      return (f & l) | (~f & `SOL_STRAP_PULL);
   endfunction

   // Expected {addr, isolate, fiber, an, speed, duplex, advert, valid}
   function automatic logic [14:0] dec(input logic [8:0] s);
      logic fib;
      fib = ~s[8];
      return {s[4:0], s[4:0] == 5'h00, fib, ~fib & s[7], fib | s[6],
              s[5], (~fib & s[7]) ? 4'h1 << s[6:5] : 4'h0, 1'b1};
   endfunction

   task automatic cmp(input logic [15:0] got, exp, input string m);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic chk_cfg(input logic [8:0] s);
      cmp({1'b0, mgmt_addr_o, isolate_o, fiber_mode_o, an_enable_o,
           speed100_o, full_duplex_o, advert_o, strap_valid_o},
          {1'b0, dec(s)}, "config");
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      reg_we_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk_i);
      reg_re_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      #1;
      cmp(reg_rdata_o, e, "read");
   endtask

   // Hardware reset with a board fit, then wait for the load
   task automatic hw_reset(input logic [8:0] f, l);
      int n;
      @(posedge clk_i);
      nrst_i <= 1'b0;
      alt_r  <= 1'b0;
      fit_r  <= f;
      lvl_r  <= l;
      repeat (7) @(posedge clk_i);
      #1;
      cmp({15'h0, strap_valid_o}, 16'h0000, "valid in reset");
      @(posedge clk_i);
      nrst_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (strap_valid_o !== 1'b1 && n < 40);
      if (n >= 40) cmp(16'h0, 16'h1, "load timeout");
      // Pins take up their normal role once captured
      @(posedge clk_i);
      alt_r <= 1'b1;
      #1;
      chk_cfg(eff(f, l));
   endtask

   ////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_default;
      hw_reset(9'h000, 9'h000);
      rd(`SOL_OFF_STRAP, 16'h01E1);
      rd(8'h10, 16'h0000);
   endtask

   task automatic t_copper;
      logic [8:0]  s;
      logic [14:0] d;
      for (int i = 0; i < 8; i++) begin
         s = {1'b1, i[2:0], 5'h03};
         d = dec(s);
         hw_reset(9'h1FF, s);
         rd(`SOL_OFF_ANAR, {7'h00, d[4:1], 5'h00});
         rd(`SOL_OFF_BMCR, {2'b00, d[6], d[7], 3'b000, d[5], 8'h00});
      end
   endtask

   task automatic t_fiber;
      for (int i = 0; i < 2; i++) begin
         hw_reset(9'h1FF, {3'b011, i[0], 5'h09});
         wr(`SOL_OFF_BMCR, 16'h3100);
         cmp({15'h0, an_enable_o}, 16'h0000, "fiber an");
      end
   endtask

   task automatic t_isolate;
      hw_reset(9'h1FF, 9'h1E0);
      wr(`SOL_OFF_ADDR, 16'h0005);
      cmp({10'h0, mgmt_addr_o, isolate_o}, 16'h000B, "iso kept");
      hw_reset(9'h1FF, 9'h1E7);
      wr(`SOL_OFF_ADDR, 16'h0000);
      cmp({10'h0, mgmt_addr_o, isolate_o}, 16'h0000, "no iso");
      rd(`SOL_OFF_ADDR, 16'h0000);
   endtask

   task automatic t_soft;
      hw_reset(9'h1FF, 9'h1F3);
      wr(`SOL_OFF_BMCR, 16'h0000);
      wr(`SOL_OFF_ADDR, 16'h0004);
      cmp({8'h0, mgmt_addr_o, an_enable_o, speed100_o, full_duplex_o},
          16'h0020, "sw fields");
      // Advertisement write lands; a write to the capture word is dropped
      wr(`SOL_OFF_ANAR, 16'h01E0);
      cmp({12'h0, advert_o}, 16'h000F, "sw advert");
      wr(`SOL_OFF_STRAP, 16'h0000);
      rd(`SOL_OFF_STRAP, 16'h01F3);
      wr(`SOL_OFF_BMCR, 16'h8000);
      repeat (2) @(posedge clk_i);
      #1;
      chk_cfg(9'h1F3);
      rd(`SOL_OFF_STRAP, 16'h01F3);
   endtask

   ////////////////////////////////////////////////////////////////
   // Verdict and run control
   task automatic conclude;
      if (mismatches == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      nrst_i = 1'b0;
      reg_we_i = 1'b0;
      reg_re_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 16'h0000;
      alt_r = 1'b0;
      fit_r = 9'h000;
      lvl_r = 9'h000;
      mismatches = 0;
      checks_done = 0;
      t_default();
      t_copper();
      t_fiber();
      t_isolate();
      t_soft();
      conclude();
   end

   // Whole run is under a thousand cycles; allow ample margin
   initial begin
      #100000;
      mismatches++;
      conclude();
   end
endmodule
